// ---- verilog/asfd_top.v ----
// asfd_top.v: ascii serial frame delimiter, framing tx and delimiting rx characters.
// assumes a character-level serial port outside (8-bit valid/ready tx stream, valid-only rx stream) and
// software on an axi4-lite bus; one clock, asynchronous active-low reset.
//
// Overview of operation
// - a nonzero start character marks the start of a received frame, zero disables it.
// - a nonzero start character is sent ahead of each transmitted payload.
// - a nonzero first end character closes the received frame when it arrives.
// - a nonzero second end character also closes the received frame when it arrives.
// - nonzero end characters are appended after the payload, first before second.
// - a nonzero length closes the received frame after that many characters.
// - a nonzero timeout closes the received frame after that many silent milliseconds.
// - length and timeout termination are never applied together.
// - with several terminations enabled the first to come true ends the frame.
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`include "asfd_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module asfd_top #(
    parameter integer CYC_PER_MS = `ASFD_CYC_PER_MS
) (
    input  wire        i_clk,
    input  wire        i_rst_b,
    // axi4-lite slave
    input  wire [7:0]  i_awaddr,
    input  wire        i_awvalid,
    output wire        o_awready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    input  wire        i_wvalid,
    output wire        o_wready,
    output reg  [1:0]  o_bresp,
    output reg         o_bvalid,
    input  wire        i_bready,
    input  wire [7:0]  i_araddr,
    input  wire        i_arvalid,
    output wire        o_arready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    output reg         o_rvalid,
    input  wire        i_rready,
    // application transmit payload
    input  wire [7:0]  i_txp_data,
    input  wire        i_txp_last,
    input  wire        i_txp_valid,
    output wire        o_txp_ready,
    // characters to the serial line
    output reg  [7:0]  o_ser_tx_data,
    output wire        o_ser_tx_valid,
    input  wire        i_ser_tx_ready,
    // characters from the serial line
    input  wire [7:0]  i_ser_rx_data,
    input  wire        i_ser_rx_valid,
    // delimited frame to the application
    output reg  [7:0]  o_rxf_data,
    output reg         o_rxf_valid,
    output reg         o_rxf_last,
    output reg  [1:0]  o_rxf_cause,
    output reg         o_rxf_eof_pulse
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg  [31:0] ctrl_q;
    reg  [31:0] delim_q;
    reg  [15:0] rxlen_q;
    reg  [15:0] rxtmo_q;
    reg         cfg_err_q;

    wire [7:0]  start_ch = delim_q[`ASFD_DELIM_START_LSB +: 8];
    wire [7:0]  end1_ch  = delim_q[`ASFD_DELIM_END1_LSB +: 8];
    wire [7:0]  end2_ch  = delim_q[`ASFD_DELIM_END2_LSB +: 8];
    wire        enable   = ctrl_q[`ASFD_CTRL_ENABLE_BIT];

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    reg         aw_have_q;
    reg         w_have_q;
    reg  [7:0]  aw_addr_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;

    assign o_awready = !aw_have_q && !o_bvalid;
    assign o_wready  = !w_have_q && !o_bvalid;

    wire        wr_go   = aw_have_q && w_have_q && !o_bvalid;
    wire [31:0] wmask   = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}},
                           {8{w_strb_q[0]}}};
    wire [31:0] rxlen_w = ({16'h0000, rxlen_q} & ~wmask) | (w_data_q & wmask);
    wire [31:0] rxtmo_w = ({16'h0000, rxtmo_q} & ~wmask) | (w_data_q & wmask);

    // capture address and data in either order, then commit and respond
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            o_bvalid  <= 1'b0;
            o_bresp   <= 2'h0;
            ctrl_q    <= `ASFD_RST_CTRL;
            delim_q   <= `ASFD_RST_DELIM;
            rxlen_q   <= `ASFD_RST_RXLEN;
            rxtmo_q   <= `ASFD_RST_RXTMO;
            cfg_err_q <= 1'b0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= i_wdata;
                w_strb_q <= i_wstrb;
            end
            if (o_bvalid && i_bready)
                o_bvalid <= 1'b0;
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                o_bvalid  <= 1'b1;
                o_bresp   <= 2'h0;
                if (aw_addr_q == `ASFD_OFS_CTRL) begin
                    ctrl_q <= (ctrl_q & ~wmask) | (w_data_q & wmask);
                end else if (aw_addr_q == `ASFD_OFS_DELIM) begin
                    delim_q <= (delim_q & ~wmask) | (w_data_q & wmask);
                end else if (aw_addr_q == `ASFD_OFS_RXLEN) begin
                    if (rxlen_w[15:0] != 16'h0000 && rxtmo_q != 16'h0000) begin
                        cfg_err_q <= 1'b1;
                        o_bresp   <= 2'h2;
                    end else begin
                        rxlen_q   <= rxlen_w[15:0];
                        cfg_err_q <= 1'b0;
                    end
                end else if (aw_addr_q == `ASFD_OFS_RXTMO) begin
                    if (rxtmo_w[15:0] != 16'h0000 && rxlen_q != 16'h0000) begin
                        cfg_err_q <= 1'b1;
                        o_bresp   <= 2'h2;
                    end else begin
                        rxtmo_q   <= rxtmo_w[15:0];
                        cfg_err_q <= 1'b0;
                    end
                end else if (aw_addr_q == `ASFD_OFS_STATUS) begin
                    o_bresp <= 2'h0; // read-only, write ignored
                end else begin
                    o_bresp <= 2'h3; // unmapped
                end
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    reg         in_frame_q;
    reg         tx_busy;

    assign o_arready = !o_rvalid;

    // decode read address into data and response
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rvalid <= 1'b0;
            o_rdata  <= 32'h0000_0000;
            o_rresp  <= 2'h0;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rresp  <= 2'h0;
            if (i_araddr == `ASFD_OFS_CTRL) begin
                o_rdata <= ctrl_q;
            end else if (i_araddr == `ASFD_OFS_DELIM) begin
                o_rdata <= delim_q;
            end else if (i_araddr == `ASFD_OFS_RXLEN) begin
                o_rdata <= {16'h0000, rxlen_q};
            end else if (i_araddr == `ASFD_OFS_RXTMO) begin
                o_rdata <= {16'h0000, rxtmo_q};
            end else if (i_araddr == `ASFD_OFS_STATUS) begin
                o_rdata <= {29'h0000_0000, tx_busy, cfg_err_q, in_frame_q};
            end else begin
                o_rdata <= 32'h0000_0000;
                o_rresp <= 2'h3;
            end
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // transmit framer
    // ------------------------------------------------------------
    localparam [4:0] TX_IDLE = 5'h01;
    localparam [4:0] TX_SOF  = 5'h02;
    localparam [4:0] TX_PAY  = 5'h04;
    localparam [4:0] TX_END1 = 5'h08;
    localparam [4:0] TX_END2 = 5'h10;

    reg  [4:0]  tx_st_q;
    reg  [4:0]  tx_st_d;

    always @* tx_busy = (tx_st_q != TX_IDLE);

    // character offered to the line in each state
    always @* begin
        case (tx_st_q)
            TX_SOF:  o_ser_tx_data = start_ch;
            TX_PAY:  o_ser_tx_data = i_txp_data;
            TX_END1: o_ser_tx_data = end1_ch;
            TX_END2: o_ser_tx_data = end2_ch;
            default: o_ser_tx_data = 8'h00;
        endcase
    end

    assign o_ser_tx_valid = (tx_st_q == TX_PAY) ? i_txp_valid : (tx_st_q != TX_IDLE);
    assign o_txp_ready    = (tx_st_q == TX_PAY) && i_ser_tx_ready;

    wire tx_take = o_ser_tx_valid && i_ser_tx_ready;

    // sequence start, payload, end characters, skipping zero delimiters
    always @* begin
        tx_st_d = tx_st_q;
        case (tx_st_q)
            TX_IDLE: begin
                if (enable && i_txp_valid)
                    tx_st_d = (start_ch != 8'h00) ? TX_SOF : TX_PAY;
            end
            TX_SOF: begin
                if (tx_take)
                    tx_st_d = TX_PAY;
            end
            TX_PAY: begin
                if (tx_take && i_txp_last)
                    tx_st_d = (end1_ch != 8'h00) ? TX_END1 :
                              (end2_ch != 8'h00) ? TX_END2 : TX_IDLE;
            end
            TX_END1: begin
                if (tx_take)
                    tx_st_d = (end2_ch != 8'h00) ? TX_END2 : TX_IDLE;
            end
            TX_END2: begin
                if (tx_take)
                    tx_st_d = TX_IDLE;
            end
            default: tx_st_d = TX_IDLE;
        endcase
    end

    // transmit state register
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            tx_st_q <= TX_IDLE;
        else
            tx_st_q <= tx_st_d;
    end

    // ------------------------------------------------------------
    // receive delimiter
    // ------------------------------------------------------------
    reg  [15:0] rx_cnt_q;
    reg  [15:0] ms_cnt_q;
    wire        ms_tick;

    wire rx_ch      = enable && i_ser_rx_valid;
    wire is_start   = (start_ch != 8'h00) && (i_ser_rx_data == start_ch);
    wire is_end     = ((end1_ch != 8'h00) && (i_ser_rx_data == end1_ch)) ||
                      ((end2_ch != 8'h00) && (i_ser_rx_data == end2_ch));
    wire open_now   = rx_ch && !in_frame_q && ((start_ch == 8'h00) || is_start);
    wire active_ch  = rx_ch && (in_frame_q || open_now);
    wire [15:0] cnt_next = open_now ? 16'h0001 : rx_cnt_q + 16'h0001;
    wire hit_count  = active_ch && (rxlen_q != 16'h0000) && (cnt_next == rxlen_q);
    wire hit_char   = active_ch && is_end;
    wire hit_silent = in_frame_q && !rx_ch && (rxtmo_q != 16'h0000) && ms_tick &&
                      (ms_cnt_q + 16'h0001 >= rxtmo_q);

    asfd_ms_tick #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_ms (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_clear (rx_ch || !in_frame_q),
        .o_tick  (ms_tick)
    );

    // frame tracking and delivery; first condition wins
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            in_frame_q      <= 1'b0;
            rx_cnt_q        <= 16'h0000;
            ms_cnt_q        <= 16'h0000;
            o_rxf_data      <= 8'h00;
            o_rxf_valid     <= 1'b0;
            o_rxf_last      <= 1'b0;
            o_rxf_cause     <= `ASFD_EOF_NONE;
            o_rxf_eof_pulse <= 1'b0;
        end else begin
            o_rxf_valid     <= active_ch;
            o_rxf_last      <= hit_char || hit_count;
            o_rxf_eof_pulse <= hit_char || hit_count || hit_silent;
            if (active_ch)
                o_rxf_data <= i_ser_rx_data;
            if (hit_char)
                o_rxf_cause <= `ASFD_EOF_CHAR;
            else if (hit_count)
                o_rxf_cause <= `ASFD_EOF_COUNT;
            else if (hit_silent)
                o_rxf_cause <= `ASFD_EOF_SILENCE;
            if (rx_ch || !in_frame_q)
                ms_cnt_q <= 16'h0000;
            else if (ms_tick)
                ms_cnt_q <= ms_cnt_q + 16'h0001;
            if (hit_char || hit_count || hit_silent) begin
                in_frame_q <= 1'b0;
                rx_cnt_q   <= 16'h0000;
            end else if (active_ch) begin
                in_frame_q <= 1'b1;
                rx_cnt_q   <= cnt_next;
            end
        end
    end

endmodule
`default_nettype wire

// ---- verilog/asfd_consts.vh ----
// asfd_consts.vh: register offsets, field layouts, reset values and timing for the
// serial frame delimiter; assumes inclusion by bare name from the design files.
`ifndef ASFD_CONSTS_VH
`define ASFD_CONSTS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define ASFD_OFS_CTRL      8'h00
`define ASFD_OFS_DELIM     8'h04
`define ASFD_OFS_RXLEN     8'h08
`define ASFD_OFS_RXTMO     8'h0C
`define ASFD_OFS_STATUS    8'h10

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ASFD_DELIM_START_LSB   0
`define ASFD_DELIM_END1_LSB    8
`define ASFD_DELIM_END2_LSB    16
`define ASFD_CTRL_ENABLE_BIT   0
`define ASFD_ST_INFRAME_BIT    0
`define ASFD_ST_CFGERR_BIT     1
`define ASFD_ST_TXBUSY_BIT     2

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define ASFD_RST_CTRL      32'h0000_0001
`define ASFD_RST_DELIM     32'h0000_0000
`define ASFD_RST_RXLEN     16'h0000
`define ASFD_RST_RXTMO     16'h0000

// ------------------------------------------------------------
// timing: one millisecond expressed in clock cycles
// ------------------------------------------------------------
`define ASFD_CLK_HZ        25000000
`define ASFD_MS_PER_S      1000
`define ASFD_CYC_PER_MS    (`ASFD_CLK_HZ / `ASFD_MS_PER_S)

// ------------------------------------------------------------
// end-of-frame cause codes
// ------------------------------------------------------------
`define ASFD_EOF_NONE      2'h0
`define ASFD_EOF_CHAR      2'h1
`define ASFD_EOF_COUNT     2'h2
`define ASFD_EOF_SILENCE   2'h3

`endif

// ---- verilog/asfd_ms_tick.v ----
// asfd_ms_tick.v: divider giving a one-cycle pulse once per millisecond.
// assumes a single free-running clock at the rate named in the constants header.
`include "asfd_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module asfd_ms_tick #(
    parameter integer CYC_PER_MS = `ASFD_CYC_PER_MS
) (
    input  wire i_clk,
    input  wire i_rst_b,
    input  wire i_clear,
    output reg  o_tick
);

    reg  [31:0] cnt_q;

    // count clock cycles, pulse at the last, restart on clear
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q  <= 32'h0000_0000;
            o_tick <= 1'b0;
        end else if (i_clear) begin
            cnt_q  <= 32'h0000_0000;
            o_tick <= 1'b0;
        end else if (cnt_q == CYC_PER_MS - 1) begin
            cnt_q  <= 32'h0000_0000;
            o_tick <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 32'h0000_0001;
            o_tick <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ---- dv/asfd_top_properties.sv ----
// asfd_top_properties.sv: port-level checker for the frame delimiter.
// assumes it is bound into asfd_top; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module asfd_props #(
    parameter integer CYC_PER_MS = 10
) (
    input wire logic        i_clk,
    input wire logic        i_rst_b,
    input wire logic        i_bready,
    input wire logic        o_bvalid,
    input wire logic [1:0]  o_bresp,
    input wire logic [7:0]  i_ser_rx_data,
    input wire logic        i_ser_rx_valid,
    input wire logic [7:0]  o_ser_tx_data,
    input wire logic        o_ser_tx_valid,
    input wire logic        i_ser_tx_ready,
    input wire logic [7:0]  o_rxf_data,
    input wire logic        o_rxf_valid,
    input wire logic        o_rxf_last,
    input wire logic [1:0]  o_rxf_cause,
    input wire logic        o_rxf_eof_pulse
);
    // ----------------------------------------
    // line silence counter and properties
    // ----------------------------------------
    integer quiet_q;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // cycles since the last received character, saturating
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            quiet_q <= 0;
        end else if (i_ser_rx_valid) begin
            quiet_q <= 0;
        end else if (quiet_q < 100000) begin
            quiet_q <= quiet_q + 1;
        end
    end
    a_rx_echo: assert property (o_rxf_valid |-> $past(i_ser_rx_valid)
        && o_rxf_data == $past(i_ser_rx_data)) else $error("rx byte not echoed");
    a_end_last: assert property (o_rxf_last |-> o_rxf_valid && o_rxf_eof_pulse)
        else $error("last byte without end");
    a_char_cause: assert property (o_rxf_eof_pulse && o_rxf_cause == 2'h1
        |-> o_rxf_last) else $error("end char cause without last byte");
    a_count_cause: assert property (o_rxf_eof_pulse && o_rxf_cause == 2'h2
        |-> o_rxf_valid && o_rxf_last) else $error("count end without byte");
    a_quiet_eof: assert property (o_rxf_eof_pulse && o_rxf_cause == 2'h3
        |-> !o_rxf_valid && quiet_q >= CYC_PER_MS) else $error("early silence end");
    a_eof_cause: assert property (o_rxf_eof_pulse |-> o_rxf_cause != 2'h0)
        else $error("frame end without cause");
    a_tx_hold: assert property (o_ser_tx_valid && !i_ser_tx_ready |=>
        o_ser_tx_valid && $stable(o_ser_tx_data)) else $error("tx char dropped");
    a_bresp_hold: assert property (o_bvalid && !i_bready |=>
        o_bvalid && $stable(o_bresp)) else $error("write response dropped");
    c_char: cover property (o_rxf_eof_pulse && o_rxf_cause == 2'h1);
    c_count: cover property (o_rxf_eof_pulse && o_rxf_cause == 2'h2);
    c_quiet: cover property (o_rxf_eof_pulse && o_rxf_cause == 2'h3);
endmodule
bind asfd_top asfd_props #(.CYC_PER_MS(CYC_PER_MS)) i_props (.i_clk, .i_rst_b,
    .i_bready, .o_bvalid, .o_bresp, .i_ser_rx_data, .i_ser_rx_valid, .o_ser_tx_data,
    .o_ser_tx_valid, .i_ser_tx_ready, .o_rxf_data, .o_rxf_valid, .o_rxf_last,
    .o_rxf_cause, .o_rxf_eof_pulse);
`default_nettype wire

// ---- dv/asfd_ser_dev.sv ----
// asfd_ser_dev.sv: simple serial device at the character level.
// assumes one clock; tx characters move on valid and ready, rx chars are pulses.
`timescale 1ns/1ps
`default_nettype none
module asfd_ser_dev (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic [7:0] i_tx_data,
    input  wire logic       i_tx_valid,
    output var  logic       o_tx_ready,
    output var  logic [7:0] o_rx_data,
    output var  logic       o_rx_valid
);
    logic [7:0] txq[$];
    logic [7:0] lfsr_q;
    initial o_rx_valid = 1'h0;
    initial o_rx_data = 8'h00;
    // capture line characters, stalling on a pseudo-random pattern
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lfsr_q <= 8'h5A;
            o_tx_ready <= 1'h0;
        end else begin
            lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
            o_tx_ready <= lfsr_q[0] | lfsr_q[2];
            if (i_tx_valid && o_tx_ready) txq.push_back(i_tx_data);
        end
    end
    // one received character, then the line shows no stale code
    task automatic send(input logic [7:0] c);
        @(posedge i_clk);
        o_rx_data <= c;
        o_rx_valid <= 1'h1;
        @(posedge i_clk);
        o_rx_valid <= 1'h0;
        o_rx_data <= ~c;
    endtask
endmodule
`default_nettype wire

// ---- dv/ascii_serial_frame_delimiter_test.sv ----
// ascii_serial_frame_delimiter_test.sv: self-checking bench for asfd_top.
// assumes the serial device model and the bound checker; 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module ascii_serial_frame_delimiter_test;
    logic        clk = 1'h0, rst_b = 1'h0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, txd = 8'h00;
    logic        awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
    logic        txl = 1'h0, txv = 1'h0, ll;
    logic [31:0] wdata = 32'h0, seed = 32'h58, d, v;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  r, ec;
    wire         awr, wr_rdy, bv, arr, rv, txr, stv, stry, srv, fv, fl, fe;
    wire  [1:0]  br, rr, fc;
    wire  [31:0] rd;
    wire  [7:0]  std, srd, fd;
    logic [7:0]  sq[$], rxq[$];
    integer      n_fail = 0, samples_checked = 0, ev_cnt = 0, t, n0;
    asfd_top #(.CYC_PER_MS(10)) i_dut (.i_clk(clk), .i_rst_b(rst_b), .i_awaddr(awaddr),
        .i_awvalid(awv), .o_awready(awr), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wv),
        .o_wready(wr_rdy), .o_bresp(br), .o_bvalid(bv), .i_bready(bry), .i_araddr(araddr),
        .i_arvalid(arv), .o_arready(arr), .o_rdata(rd), .o_rresp(rr), .o_rvalid(rv),
        .i_rready(rry), .i_txp_data(txd), .i_txp_last(txl), .i_txp_valid(txv),
        .o_txp_ready(txr), .o_ser_tx_data(std), .o_ser_tx_valid(stv),
        .i_ser_tx_ready(stry), .i_ser_rx_data(srd), .i_ser_rx_valid(srv),
        .o_rxf_data(fd), .o_rxf_valid(fv), .o_rxf_last(fl), .o_rxf_cause(fc),
        .o_rxf_eof_pulse(fe));
    asfd_ser_dev i_dev (.i_clk(clk), .i_rst_b(rst_b), .i_tx_data(std), .i_tx_valid(stv),
        .o_tx_ready(stry), .o_rx_data(srd), .o_rx_valid(srv));
    // ----------------------------------------
    // clock, monitor and helpers
    // ----------------------------------------
    initial forever #20 clk = ~clk;
    // collect delimited bytes and frame ends
    always @(posedge clk) begin
        if (fv === 1'h1) rxq.push_back(fd);
        if (fe === 1'h1) begin
            ev_cnt++;
            ec = fc;
            ll = fl;
        end
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // expected word after a strobed write: enabled bytes new, the rest kept
    function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
        for (int b = 0; b < 4; b++) if (s[b]) o[8*b +: 8] = n[8*b +: 8];
        return o;
    endfunction
    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        integer n;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awv <= 1'h1;
        wv <= 1'h1;
        bry <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awv && awr) awv <= 1'h0;
            if (wv && wr_rdy) wv <= 1'h0;
            if (bv === 1'h1) break;
        end
        bry <= 1'h0;
        if (n == 50) n_fail++;
        if (n == 50) wrap_up();
        chk("bresp", er, br);
    endtask
    task automatic rdr(input logic [7:0] a);
        integer n;
        @(posedge clk);
        araddr <= a;
        arv <= 1'h1;
        rry <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arv && arr) arv <= 1'h0;
            if (rv === 1'h1) break;
        end
        rry <= 1'h0;
        d = rd;
        r = rr;
        if (n == 50) n_fail++;
        if (n == 50) wrap_up();
    endtask
    task automatic wait_ev(input integer lim);
        integer n;
        for (n = 0; n < lim && ev_cnt == n0; n++) @(posedge clk);
        if (n == lim) n_fail++;
        if (n == lim) wrap_up();
    endtask
    task automatic fill(input logic [7:0] s, input integer k);
        sq.delete();
        sq.push_back(s);
        repeat (k) sq.push_back(8'h41 + 8'(xs() % 26));
    endtask
    task automatic tx_frame(input logic [31:0] dl, input integer n);
        integer i, k;
        sq.delete();
        if (dl[7:0] != 8'h00) sq.push_back(dl[7:0]);
        for (i = 0; i < n; i++) begin
            sq.push_back(8'(xs()));
            txd <= sq[sq.size() - 1];
            txl <= (i == n - 1);
            txv <= 1'h1;
            for (k = 0; k < 200 && !(k > 0 && txr === 1'h1); k++) @(posedge clk);
            if (k == 200) n_fail++;
            if (k == 200) wrap_up();
        end
        txv <= 1'h0;
        if (dl[15:8] != 8'h00) sq.push_back(dl[15:8]);
        if (dl[23:16] != 8'h00) sq.push_back(dl[23:16]);
        for (k = 0; k < 200 && i_dev.txq.size() < sq.size(); k++) @(posedge clk);
        chk("tx_len", sq.size(), i_dev.txq.size());
        foreach (sq[i]) chk("tx_char", sq[i], i_dev.txq[i]);
        i_dev.txq.delete();
    endtask
    task automatic rx_run(input logic [1:0] cause);
        n0 = ev_cnt;
        rxq.delete();
        foreach (sq[i]) i_dev.send(sq[i]);
        wait_ev(200);
        chk("rx_len", sq.size(), rxq.size());
        foreach (sq[i]) chk("rx_char", sq[i], rxq[i]);
        chk("rx_cause", cause, ec);
        chk("rx_last", 32'h1, ll);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'h1;
        rdr(8'h00);
        chk("ctrl", 32'h1, d);
        rdr(8'h04);
        chk("delim", 32'h0, d);
        rdr(8'h14 + 8'(4 * (xs() % 59)));
        chk("rresp", 2'h3, r);
        wstrb <= 4'(xs());
        v = xs();
        wr(8'h04, v, 2'h0);
        rdr(8'h04);
        chk("delim_strb", mrg(32'h0, v, wstrb), d);
        wstrb <= 4'hF;
        $display("test regs done");
        for (t = 0; t < 2; t++) begin
            wr(8'h04, t == 0 ? 32'h000A0D3A : 32'h00000D00, 2'h0);
            tx_frame(t == 0 ? 32'h000A0D3A : 32'h00000D00, 1 + xs() % 4);
        end
        $display("test tx done");
        wr(8'h04, 32'h000A0D3A, 2'h0);
        for (t = 0; t < 2; t++) begin
            i_dev.send(8'h42);
            fill(8'h3A, 1 + xs() % 5);
            sq.push_back(t == 0 ? 8'h0D : 8'h0A);
            rx_run(2'h1);
        end
        $display("test end chars done");
        wr(8'h08, 32'h4, 2'h0);
        fill(8'h3A, 3);
        rx_run(2'h2);
        fill(8'h3A, 1);
        sq.push_back(8'h0D);
        rx_run(2'h1);
        $display("test count done");
        wr(8'h0C, 32'h3, 2'h2);
        rdr(8'h10);
        chk("cfg_err", 32'h2, d);
        rdr(8'h0C);
        chk("rxtmo", 32'h0, d);
        wr(8'h08, 32'h0, 2'h0);
        wr(8'h0C, 32'h3, 2'h0);
        n0 = ev_cnt;
        rxq.delete();
        i_dev.send(8'h3A);
        i_dev.send(8'h51);
        repeat (20) @(posedge clk);
        chk("early_end", n0, ev_cnt);
        i_dev.send(8'h52);
        wait_ev(100);
        chk("quiet_cause", 2'h3, ec);
        chk("quiet_len", 3, rxq.size());
        chk("quiet_last", 32'h0, ll);
        $display("test silence done");
        wr(8'h00, 32'h0, 2'h0);
        n0 = ev_cnt;
        rxq.delete();
        i_dev.send(8'h3A);
        i_dev.send(8'h0D);
        repeat (4) @(posedge clk);
        chk("off_len", 0, rxq.size());
        chk("off_end", n0, ev_cnt);
        $display("test disable done");
        wrap_up();
    end
endmodule
`default_nettype wire
